// File: include/bmf_defs.svh
// Constants and behaviour notes for the block multiplexer channel function executor
// Notes on behaviour
// - Channel command clears Done, sets Busy; on completion clears Busy, sets Done.
// - Command byte is parameter bits 7..0; bits 15..8 are ignored.
// - Test I/O is all zeros with parity one; low bits select write, read, control.
// - Command byte goes out only during initial selection, never later.
// - Selection ends on ending, zero or error status; zero status opens data phase unless Test I/O or count zero.
// - Data transfer ends when count reaches zero with no chaining pending.
// - Data transfer also ends when unit answers with status-in instead of service-in.
// - Done waits until the sequence ends and memory traffic has completed.
// - Request-in read sets Busy; on request-in captures address, checks parity, sets Done.
// - Without request-in, Done sets while Busy stays set.
// - Asynchronous I/O sets Busy; present status-in is captured into the status register.
// - With stack status enabled, answer with command-out instead of service-out.
// - Asynchronous I/O ends by setting Done and clearing Busy.
// - Delay diagnostic sets Busy, waits ten microseconds, then sets Done.
// - Clear-interrupt-enable clears the enable only; Busy and Done untouched.
// - Enabled interrupt on Done, selected input tag, or chained segment completion.
// - Two address registers; read-address returns one chosen by bit 0, echoed in bit 0.
// - Read-address result bit 1 shows chaining for the returned register.
// - Read-address clears the pending chaining interrupt; allowed any time.
// - Odd parity checked on address, status, data inputs; generated on outputs.
// - Byte counter holds remaining bytes; reloads from next count when chaining.
`ifndef BMF_DEFS_SVH
`define BMF_DEFS_SVH

// Function codes
`define BMF_FN_CMD 4'h2
`define BMF_FN_REQ 4'h3
`define BMF_FN_ASYNC 4'h4
`define BMF_FN_DELAY 4'h5
`define BMF_FN_IE_CLR 4'h6
`define BMF_FN_IE_SET 4'h7
`define BMF_FN_RD_ADDR 4'h8

// Command byte encoding
`define BMF_CMD_TEST 8'h00
`define BMF_CMD_WR 2'h1
`define BMF_CMD_RD 2'h2
`define BMF_CMD_SENSE 4'h4
`define BMF_CMD_RDBK 4'hC

// Timing
`define BMF_CLK_NS 5
`define BMF_DELAY_NS 10000
`define BMF_REQ_WAIT_NS 1000
`define BMF_DELAY_CYC ((`BMF_DELAY_NS + `BMF_CLK_NS - 1) / `BMF_CLK_NS)
`define BMF_REQ_WAIT_CYC (`BMF_REQ_WAIT_NS / `BMF_CLK_NS)
`define BMF_TMR_W 12

// Widths and positions
`define BMF_SYNC_W 14
`define BMF_ONE_COUNT 16'h0001
`define BMF_ZERO_COUNT 16'h0000
`define BMF_ADDR_LSB 2
`define BMF_CHAIN_BIT 1

`endif

// File: include/bmf_pkg.sv
// Types and helpers shared by the channel function executor
package bmf_pkg;
  typedef enum logic [3:0] {
    BMF_S_IDLE = 4'h0,
    BMF_S_SEL = 4'h1,
    BMF_S_CMD = 4'h2,
    BMF_S_CSTAT = 4'h3,
    BMF_S_XFER = 4'h4,
    BMF_S_MEMR = 4'h5,
    BMF_S_MEMW = 4'h6,
    BMF_S_RESP = 4'h7,
    BMF_S_REQ = 4'h8,
    BMF_S_ASYNC = 4'h9,
    BMF_S_AHOLD = 4'hA,
    BMF_S_DELAY = 4'hB,
    BMF_S_END = 4'hC
  } bmf_state_t;

  // Odd parity bit for a byte
  function automatic logic bmf_odd_par(input logic [7:0] data);
    bmf_odd_par = ~(^data);
  endfunction
endpackage

// File: include/bmf_timer_if.sv
// Start and expiry handshake between executor and its timer
`timescale 1ns/1ps
interface bmf_timer_if;
  logic start;
  logic [11:0] load;
  logic expired;
  modport ctl(output start, output load, input expired);
  modport tmr(input start, input load, output expired);
endinterface

// File: core/bmf_sync.sv
// Two-stage synchroniser for asynchronous channel inputs
`timescale 1ns/1ps
module bmf_sync #(
  parameter int WIDTH = 14
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          meta_q[gi] <= 1'b0;
          sync_o[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= async_i[gi];
          sync_o[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate
endmodule

// File: core/bmf_timer.sv
// One-shot down counter with expiry pulse
`timescale 1ns/1ps
module bmf_timer
  import bmf_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Control
  bmf_timer_if.tmr tif
);
  logic [11:0] cnt_q;
  logic run_q;
  logic exp_q;
  wire last_tick = run_q & (cnt_q == 12'h001);

  assign tif.expired = exp_q;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= 12'h000;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      exp_q <= last_tick & ~tif.start;
      if (tif.start) begin
        cnt_q <= tif.load;
        run_q <= 1'b1;
      end else if (run_q) begin
        cnt_q <= cnt_q - 12'h001;
        run_q <= ~last_tick;
      end
    end
  end
endmodule

// File: core/bmf_channel_fn.sv
// Per-channel function executor of a byte-wide block multiplexer channel
`timescale 1ns/1ps
`include "bmf_defs.svh"
module bmf_channel_fn
  import bmf_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Function port from the processor
  input wire logic fn_valid_i,
  input wire logic [3:0] fn_code_i,
  input wire logic [15:0] fn_param_i,
  output logic fn_ready_o,
  output logic [15:0] result_o,
  output logic result_valid_o,
  // Channel flags
  output logic busy_o,
  output logic done_o,
  output logic irq_o,
  output logic int_enable_o,
  output logic parity_err_o,
  output logic [7:0] status_o,
  output logic [7:0] req_addr_o,
  output logic [15:0] count_o,
  // Setup entries
  input wire logic lma_we_i,
  input wire logic [15:0] lma_i,
  input wire logic count_we_i,
  input wire logic [15:0] count_i,
  input wire logic next_count_we_i,
  input wire logic [15:0] next_count_i,
  input wire logic [7:0] dev_addr_i,
  input wire logic stack_status_i,
  input wire logic [4:0] irq_tag_sel_i,
  // Channel bus to the control unit
  output logic [7:0] bus_out_o,
  output logic bus_out_par_o,
  output logic addr_out_o,
  output logic cmd_out_o,
  output logic srv_out_o,
  input wire logic [7:0] bus_in_i,
  input wire logic bus_in_par_i,
  input wire logic op_in_i,
  input wire logic addr_in_i,
  input wire logic stat_in_i,
  input wire logic srv_in_i,
  input wire logic req_in_i,
  // Local memory port
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [13:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  input wire logic [7:0] mem_rdata_i,
  input wire logic mem_ack_i
);
  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  logic [13:0] sync_w;
  bmf_sync #(.WIDTH(`BMF_SYNC_W)) u_sync (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .async_i({bus_in_par_i, bus_in_i, op_in_i, addr_in_i, stat_in_i, srv_in_i, req_in_i}),
    .sync_o(sync_w)
  );
  wire bus_par_s = sync_w[13];
  wire [7:0] bus_in_s = sync_w[12:5];
  wire [4:0] tags_s = sync_w[4:0];
  wire addr_in_s = sync_w[3];
  wire stat_in_s = sync_w[2];
  wire srv_in_s = sync_w[1];
  wire req_in_s = sync_w[0];

  // ----------------------------------------
  // Timer
  // ----------------------------------------
  bmf_timer_if tif();
  logic tmr_start_q;
  logic [11:0] tmr_load_q;
  assign tif.start = tmr_start_q;
  assign tif.load = tmr_load_q;
  bmf_timer u_timer (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .tif(tif)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  bmf_state_t state_q;
  logic idle_q;
  logic busy_q;
  logic done_q;
  logic int_en_q;
  logic irq_q;
  logic [7:0] cmd_q;
  logic [7:0] status_q;
  logic [7:0] req_addr_q;
  logic par_err_q;
  logic [7:0] bus_out_q;
  logic bus_par_q;
  logic addr_out_q;
  logic cmd_out_q;
  logic srv_out_q;
  logic mem_req_q;
  logic mem_we_q;
  logic [7:0] mem_wdata_q;
  logic [15:0] lma_q [2];
  logic cur_q;
  logic [15:0] count_q;
  logic [15:0] next_count_q;
  logic chain_irq_q;
  logic [15:0] result_q;
  logic result_vld_q;

  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  wire take_fn = fn_valid_i & idle_q;
  wire is_cmd = fn_code_i == `BMF_FN_CMD;
  wire is_req = fn_code_i == `BMF_FN_REQ;
  wire is_async = fn_code_i == `BMF_FN_ASYNC;
  wire is_delay = fn_code_i == `BMF_FN_DELAY;
  // Busy-sequence functions wait for the idle state; the rest run any time
  // one at a time
  wire start_seq = take_fn & (is_cmd | is_req | is_async | is_delay);
  wire ie_clr = fn_valid_i & (fn_code_i == `BMF_FN_IE_CLR);
  wire ie_set = fn_valid_i & (fn_code_i == `BMF_FN_IE_SET);
  wire rd_addr = fn_valid_i & (fn_code_i == `BMF_FN_RD_ADDR);
  wire cmd_test = cmd_q == `BMF_CMD_TEST;
  wire cmd_rdbk = cmd_q[3:0] == `BMF_CMD_RDBK;
  wire cmd_inbound = (cmd_q[1:0] == `BMF_CMD_RD) | (cmd_q[3:0] == `BMF_CMD_SENSE) | cmd_rdbk;
  wire in_par_bad = bus_par_s != bmf_odd_par(bus_in_s);
  wire status_zero = status_q == 8'h00;
  wire last_byte = count_q == `BMF_ONE_COUNT;
  wire chain_on = lma_q[cur_q][`BMF_CHAIN_BIT];
  wire [13:0] cur_addr = lma_q[cur_q][15:`BMF_ADDR_LSB];
  wire [13:0] step_addr = cmd_rdbk ? cur_addr - 14'h0001 : cur_addr + 14'h0001;
  wire rd_sel = fn_param_i[0];
  wire [15:0] rd_word = {lma_q[rd_sel][15:`BMF_ADDR_LSB], lma_q[rd_sel][`BMF_CHAIN_BIT], rd_sel};
  wire tag_hit = |(tags_s & irq_tag_sel_i);
  wire seg_done = (state_q == BMF_S_RESP) & ~srv_in_s & last_byte & chain_on;

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign fn_ready_o = idle_q;
  assign result_o = result_q;
  assign result_valid_o = result_vld_q;
  assign busy_o = busy_q;
  assign done_o = done_q;
  assign irq_o = irq_q;
  assign int_enable_o = int_en_q;
  assign parity_err_o = par_err_q;
  assign status_o = status_q;
  assign req_addr_o = req_addr_q;
  assign count_o = count_q;
  assign bus_out_o = bus_out_q;
  assign bus_out_par_o = bus_par_q;
  assign addr_out_o = addr_out_q;
  assign cmd_out_o = cmd_out_q;
  assign srv_out_o = srv_out_q;
  assign mem_req_o = mem_req_q;
  assign mem_we_o = mem_we_q;
  assign mem_addr_o = cur_addr;
  assign mem_wdata_o = mem_wdata_q;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= BMF_S_IDLE;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      cmd_q <= 8'h00;
      status_q <= 8'h00;
      req_addr_q <= 8'h00;
      par_err_q <= 1'b0;
      bus_out_q <= 8'h00;
      addr_out_q <= 1'b0;
      cmd_out_q <= 1'b0;
      srv_out_q <= 1'b0;
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_wdata_q <= 8'h00;
      cur_q <= 1'b0;
      tmr_start_q <= 1'b0;
      tmr_load_q <= 12'h000;
    end else begin
      tmr_start_q <= 1'b0;
      case (state_q)
        BMF_S_IDLE: begin
          if (start_seq) begin
            done_q <= 1'b0;
            busy_q <= 1'b1;
            par_err_q <= 1'b0;
            if (is_cmd) begin
              cmd_q <= fn_param_i[7:0];
              cur_q <= 1'b0;
              bus_out_q <= dev_addr_i;
              addr_out_q <= 1'b1;
              state_q <= BMF_S_SEL;
            end else if (is_req) begin
              tmr_load_q <= `BMF_TMR_W'(`BMF_REQ_WAIT_CYC);
              tmr_start_q <= 1'b1;
              state_q <= BMF_S_REQ;
            end else if (is_async) begin
              state_q <= BMF_S_ASYNC;
            end else begin
              tmr_load_q <= `BMF_TMR_W'(`BMF_DELAY_CYC);
              tmr_start_q <= 1'b1;
              state_q <= BMF_S_DELAY;
            end
          end
        end
        BMF_S_SEL: begin
          if (addr_in_s) begin
            addr_out_q <= 1'b0;
            bus_out_q <= cmd_q;
            cmd_out_q <= 1'b1;
            state_q <= BMF_S_CMD;
          end
        end
        BMF_S_CMD: begin
          if (stat_in_s) begin
            cmd_out_q <= 1'b0;
            bus_out_q <= 8'h00;
            status_q <= bus_in_s;
            par_err_q <= par_err_q | in_par_bad;
            srv_out_q <= 1'b1;
            state_q <= BMF_S_CSTAT;
          end
        end
        BMF_S_CSTAT: begin
          if (!stat_in_s) begin
            srv_out_q <= 1'b0;
            if (status_zero && !cmd_test && count_q != `BMF_ZERO_COUNT) begin
              state_q <= BMF_S_XFER;
            end else begin
              state_q <= BMF_S_END;
            end
          end
        end
        BMF_S_XFER: begin
          if (stat_in_s) begin
            status_q <= bus_in_s;
            par_err_q <= par_err_q | in_par_bad;
            srv_out_q <= 1'b1;
            state_q <= BMF_S_AHOLD;
          end else if (srv_in_s) begin
            mem_req_q <= 1'b1;
            mem_we_q <= cmd_inbound;
            mem_wdata_q <= bus_in_s;
            if (cmd_inbound) begin
              par_err_q <= par_err_q | in_par_bad;
            end
            state_q <= cmd_inbound ? BMF_S_MEMW : BMF_S_MEMR;
          end
        end
        BMF_S_MEMR: begin
          if (mem_ack_i) begin
            mem_req_q <= 1'b0;
            bus_out_q <= mem_rdata_i;
            srv_out_q <= 1'b1;
            state_q <= BMF_S_RESP;
          end
        end
        BMF_S_MEMW: begin
          // answer only after memory has taken the byte
          if (mem_ack_i) begin
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            srv_out_q <= 1'b1;
            state_q <= BMF_S_RESP;
          end
        end
        BMF_S_RESP: begin
          if (!srv_in_s) begin
            srv_out_q <= 1'b0;
            if (last_byte && chain_on) begin
              cur_q <= ~cur_q;
              state_q <= BMF_S_XFER;
            end else if (last_byte) begin
              state_q <= BMF_S_END;
            end else begin
              state_q <= BMF_S_XFER;
            end
          end
        end
        BMF_S_REQ: begin
          if (req_in_s) begin
            req_addr_q <= bus_in_s;
            par_err_q <= in_par_bad;
            state_q <= BMF_S_END;
          end else if (tif.expired) begin
            done_q <= 1'b1;
            state_q <= BMF_S_IDLE;
          end
        end
        BMF_S_ASYNC: begin
          if (stat_in_s) begin
            status_q <= bus_in_s;
            par_err_q <= in_par_bad;
            cmd_out_q <= stack_status_i;
            srv_out_q <= ~stack_status_i;
            state_q <= BMF_S_AHOLD;
          end else begin
            state_q <= BMF_S_END;
          end
        end
        BMF_S_AHOLD: begin
          if (!stat_in_s) begin
            cmd_out_q <= 1'b0;
            srv_out_q <= 1'b0;
            state_q <= BMF_S_END;
          end
        end
        BMF_S_DELAY: begin
          if (tif.expired) begin
            state_q <= BMF_S_END;
          end
        end
        BMF_S_END: begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          state_q <= BMF_S_IDLE;
        end
        default: begin
          state_q <= BMF_S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Address, count and parity out
  // ----------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lma_q[0] <= 16'h0000;
      lma_q[1] <= 16'h0000;
      count_q <= 16'h0000;
      next_count_q <= 16'h0000;
      bus_par_q <= 1'b1;
    end else begin
      // parity on outputs follows the driven byte
      bus_par_q <= bmf_odd_par(bus_out_q);
      if (state_q == BMF_S_RESP && !srv_in_s) begin
        lma_q[cur_q][15:`BMF_ADDR_LSB] <= step_addr;
        count_q <= (last_byte && chain_on) ? next_count_q : count_q - `BMF_ONE_COUNT;
      end
      // Setup entries win; software must not reload mid-transfer
      if (lma_we_i) begin
        lma_q[lma_i[0]] <= lma_i;
      end
      if (count_we_i) begin
        count_q <= count_i;
      end
      if (next_count_we_i) begin
        next_count_q <= next_count_i;
      end
    end
  end

  // ----------------------------------------
  // Flags, readback and interrupt
  // ----------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idle_q <= 1'b1;
      int_en_q <= 1'b0;
      chain_irq_q <= 1'b0;
      result_q <= 16'h0000;
      result_vld_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      idle_q <= (state_q == BMF_S_IDLE) ? ~start_seq : (state_q == BMF_S_END) |
                (state_q == BMF_S_REQ && !req_in_s && tif.expired);
      if (ie_clr) begin
        int_en_q <= 1'b0;
      end else if (ie_set) begin
        int_en_q <= 1'b1;
      end
      result_vld_q <= rd_addr;
      if (rd_addr) begin
        result_q <= rd_word;
      end
      // read-address clears, a new segment end still wins
      if (seg_done) begin
        chain_irq_q <= 1'b1;
      end else if (rd_addr) begin
        chain_irq_q <= 1'b0;
      end
      irq_q <= int_en_q & (done_q | tag_hit | chain_irq_q);
    end
  end
endmodule

// File: tb/bmf_channel_fn_monitor.sv
// Port checker for the channel function executor
`timescale 1ns/1ps
module bmf_channel_fn_monitor (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Function port
  input wire logic fn_valid_i,
  input wire logic [3:0] fn_code_i,
  input wire logic [15:0] fn_param_i,
  input wire logic fn_ready_o,
  input wire logic [15:0] result_o,
  input wire logic result_valid_o,
  // Flags and channel outputs
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic irq_o,
  input wire logic int_enable_o,
  input wire logic [7:0] bus_out_o,
  input wire logic bus_out_par_o,
  input wire logic cmd_out_o
);
  logic go;
  logic cmd_fn_q;
  logic sel_q;
  logic [7:0] cmd_q;
  logic dly_run_q;
  logic [11:0] dly_cnt_q;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  assign go = fn_valid_i && fn_ready_o && fn_code_i >= 4'h2 && fn_code_i <= 4'h5;
  // Command byte and delay span kept for checks
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd_q <= 8'h00;
      cmd_fn_q <= 1'b0;
      sel_q <= 1'b0;
      dly_run_q <= 1'b0;
      dly_cnt_q <= 12'h000;
    end else begin
      dly_cnt_q <= go ? 12'h001 : dly_cnt_q + 12'h001;
      dly_run_q <= go ? (fn_code_i == 4'h5) : dly_run_q && !done_o;
      if (go) begin
        cmd_q <= fn_param_i[7:0];
        cmd_fn_q <= (fn_code_i == 4'h2);
      end else if (fn_valid_i && fn_code_i == 4'h8) begin
        sel_q <= fn_param_i[0];
      end
    end
  end
  a_busy_start: assert property (go |=> busy_o && !done_o && !fn_ready_o)
    else $error("busy sequence did not start");
  a_done_ready: assert property ($rose(done_o) |-> fn_ready_o)
    else $error("done without ready");
  a_out_parity: assert property (bus_out_par_o == ~(^$past(bus_out_o)))
    else $error("output parity not odd");
  a_ie_clear: assert property (fn_valid_i && fn_code_i == 4'h6 && fn_ready_o && !busy_o
    |=> !int_enable_o && $stable(busy_o) && $stable(done_o))
    else $error("enable clear misbehaved");
  a_ie_set: assert property (fn_valid_i && fn_code_i == 4'h7 |=> int_enable_o)
    else $error("enable not set");
  a_irq_done: assert property (int_enable_o && done_o |=> irq_o)
    else $error("no interrupt on done");
  a_irq_gate: assert property (!int_enable_o |=> !irq_o)
    else $error("interrupt while disabled");
  a_rd_echo: assert property (fn_valid_i && fn_code_i == 4'h8
    |=> result_valid_o && result_o[0] == sel_q)
    else $error("register identity not echoed");
  a_cmd_byte: assert property ($rose(cmd_out_o) && cmd_fn_q |-> bus_out_o == cmd_q)
    else $error("wrong command byte");
  a_delay_span: assert property (dly_run_q |-> dly_cnt_q <= 12'h7DA &&
    (!done_o || (dly_cnt_q >= 12'h7CB && !busy_o)))
    else $error("delay span wrong");
  c_chain_rd: cover property (result_valid_o && result_o[1]);
  c_stack: cover property ($rose(cmd_out_o) && !cmd_fn_q);
  c_irq: cover property (int_enable_o && done_o ##1 irq_o);
endmodule
bind bmf_channel_fn bmf_channel_fn_monitor i_bmf_channel_fn_monitor (.core_clk_i, .rstn_i,
  .fn_valid_i, .fn_code_i, .fn_param_i, .fn_ready_o, .result_o, .result_valid_o, .busy_o,
  .done_o, .irq_o, .int_enable_o, .bus_out_o, .bus_out_par_o, .cmd_out_o);

// File: tb/bmf_cu_model.sv
// Control unit model on the far side of the byte channel
`timescale 1ns/1ps
module bmf_cu_model (
  // Clock and script
  input wire logic core_clk_i,
  input wire logic [7:0] sel_stat_i,
  input wire logic [3:0] nbytes_i,
  input wire logic early_stat_i,
  input wire logic [2:0] lag_i,
  // Channel tags
  input wire logic [7:0] bus_out_i,
  input wire logic addr_out_i,
  input wire logic cmd_out_i,
  input wire logic srv_out_i,
  output logic addr_in_o,
  output logic stat_in_o,
  output logic srv_in_o,
  output logic [7:0] bus_o
);
  task automatic pace();
    repeat (int'(lag_i) + 1) @(negedge core_clk_i);
  endtask
  initial begin
    addr_in_o = 1'b0;
    stat_in_o = 1'b0;
    srv_in_o = 1'b0;
    bus_o = 8'h5A;
    forever begin
      @(posedge addr_out_i);
      pace();
      addr_in_o = 1'b1;
      bus_o = bus_out_i;
      // selection ends with the scripted status
      wait (cmd_out_i);
      pace();
      addr_in_o = 1'b0;
      stat_in_o = 1'b1;
      bus_o = sel_stat_i;
      wait (srv_out_i);
      pace();
      stat_in_o = 1'b0;
      bus_o = ~bus_o;
      for (int i = 0; i < nbytes_i; i++) begin
        wait (!srv_out_i);
        pace();
        srv_in_o = 1'b1;
        bus_o = 8'hC0 + 8'(i);
        wait (srv_out_i);
        pace();
        srv_in_o = 1'b0;
        bus_o = ~bus_o;
      end
      // status in place of service ends early
      if (early_stat_i) begin
        wait (!srv_out_i);
        pace();
        stat_in_o = 1'b1;
        bus_o = 8'h0C;
        wait (srv_out_i);
        pace();
        stat_in_o = 1'b0;
        bus_o = ~bus_o;
      end
    end
  end
endmodule

// File: tb/bmf_channel_fn_tb_top.sv
// Self-checking bench for the channel function executor
`timescale 1ns/1ps
`include "bmf_defs.svh"
module bmf_channel_fn_tb_top;
  logic core_clk_i = 1'b0, rstn_i = 1'b0, fn_valid_i = 1'b0, lma_we_i = 1'b0, count_we_i = 1'b0;
  logic next_count_we_i = 1'b0, stack_status_i = 1'b0, mem_ack_i = 1'b0, req_in_i = 1'b0;
  logic tb_stat = 1'b0, early = 1'b0, cu_stat, bus_in_par_i, op_in_i, addr_in_i, stat_in_i;
  logic srv_in_i, fn_ready_o, result_valid_o, busy_o, done_o, irq_o, int_enable_o;
  logic parity_err_o, addr_out_o, cmd_out_o, srv_out_o, bus_out_par_o, mem_req_o, mem_we_o;
  logic [3:0] fn_code_i = 4'h0, nbytes = 4'h0;
  logic [2:0] lag = 3'h0;
  logic [4:0] irq_tag_sel_i = 5'h00;
  logic [15:0] fn_param_i = 16'h0000, lma_i = 16'h0000, count_i = 16'h0000;
  logic [15:0] next_count_i = 16'h0000, result_o, count_o;
  logic [7:0] dev_addr_i = 8'h33, mem_rdata_i = 8'h00, raddr = 8'h00, sel_stat = 8'h00;
  logic [7:0] bus_in_i, cu_bus, status_o, req_addr_o, bus_out_o, mem_wdata_o;
  logic [13:0] mem_addr_o;
  logic [15:0] wq[$];
  int miscompares = 0, comparisons = 0, n;
  assign bus_in_i = (req_in_i | tb_stat) ? raddr : cu_bus;
  assign bus_in_par_i = ~(^bus_in_i);
  assign stat_in_i = cu_stat | tb_stat;
  assign op_in_i = 1'b0;
  always #2.5 core_clk_i = ~core_clk_i;
  bmf_channel_fn i_bmf_channel_fn (.*);
  bmf_cu_model i_bmf_cu_model (.core_clk_i(core_clk_i), .sel_stat_i(sel_stat),
    .nbytes_i(nbytes), .early_stat_i(early), .lag_i(lag), .bus_out_i(bus_out_o),
    .addr_out_i(addr_out_o), .cmd_out_i(cmd_out_o), .srv_out_i(srv_out_o),
    .addr_in_o(addr_in_i), .stat_in_o(cu_stat), .srv_in_o(srv_in_i), .bus_o(cu_bus));
  // Memory acknowledges one cycle on, logging writes
  always @(negedge core_clk_i) begin
    mem_ack_i <= 1'b0;
    if (mem_req_o && !mem_ack_i) begin
      mem_ack_i <= 1'b1;
      mem_rdata_i <= mem_addr_o[7:0] ^ 8'h96;
      if (mem_we_o) wq.push_back({mem_addr_o[7:0], mem_wdata_o});
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic fn(input logic [3:0] c, input logic [15:0] p);
    @(negedge core_clk_i);
    fn_valid_i = 1'b1;
    fn_code_i = c;
    fn_param_i = p;
    @(negedge core_clk_i);
    fn_valid_i = 1'b0;
  endtask
  task automatic wait_done(input int lim);
    n = 0;
    while (done_o !== 1'b1 && n < lim) begin
      @(negedge core_clk_i);
      n++;
    end
  endtask
  task automatic ent(input logic [15:0] a, input logic [15:0] c, input logic [15:0] x);
    @(negedge core_clk_i);
    {lma_i, count_i, next_count_i} = {a, c, x};
    {lma_we_i, count_we_i, next_count_we_i} = 3'b111;
    @(negedge core_clk_i);
    {lma_we_i, count_we_i, next_count_we_i} = 3'b000;
  endtask
  task automatic cmd(input logic [15:0] p, input logic [7:0] st, input logic [3:0] nb,
                     input logic e);
    {sel_stat, nbytes, early} = {st, nb, e};
    wq.delete();
    fn(4'h2, p);
    wait_done(600);
    chk("cmd busy", 1'b0, busy_o);
  endtask
  task automatic summarize();
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Time limit of 40k cycles, well above the tests
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
  initial begin
    repeat (10) @(negedge core_clk_i);
    chk("reset flags", 3'b100, {fn_ready_o, busy_o, done_o});
    rstn_i = 1'b1;
    fn(4'h7, 16'h0000);
    chk("ie set", 1'b1, int_enable_o);
    fn(4'h5, 16'h0000);
    @(negedge core_clk_i);
    chk("delay busy", 2'b10, {busy_o, done_o});
    fn(4'h3, 16'h0000);
    wait_done(3000);
    chk("delay span", 1'b1, n + 4 >= `BMF_DELAY_CYC && n + 4 <= `BMF_DELAY_CYC + 6);
    @(negedge core_clk_i);
    chk("delay end", 3'b011, {busy_o, done_o, irq_o});
    fn(4'h6, 16'h0000);
    @(negedge core_clk_i);
    chk("ie clear", 4'b0010, {int_enable_o, busy_o, done_o, irq_o});
    // Request-in raised with address 5C, then left low; interrupts off ahead of async work
    raddr = 8'h5C;
    fn(4'h3, 16'h0000);
    repeat (5) @(negedge core_clk_i);
    req_in_i = 1'b1;
    wait_done(50);
    req_in_i = 1'b0;
    chk("req addr", 8'h5C, req_addr_o);
    chk("req flags", 2'b00, {busy_o, parity_err_o});
    fn(4'h3, 16'h0000);
    wait_done(400);
    chk("no req", 2'b11, {busy_o, done_o});
    for (int s = 0; s < 2; s++) begin
      stack_status_i = s[0];
      raddr = 8'h40 + 8'(s);
      tb_stat = 1'b1;
      repeat (3) @(negedge core_clk_i);
      fn(4'h4, 16'h0000);
      n = 0;
      while ((s[0] ? cmd_out_o : srv_out_o) !== 1'b1 && n < 20) begin
        @(negedge core_clk_i);
        n++;
      end
      chk("stop tag", {s[0], ~s[0]}, {cmd_out_o, srv_out_o});
      chk("async stat", raddr, status_o);
      tb_stat = 1'b0;
      wait_done(40);
      chk("async end", 1'b0, busy_o);
    end
    stack_status_i = 1'b0;
    ent(16'h0010, 16'h0003, 16'h0000);
    cmd(16'hFF02, 8'h00, 4'd3, 1'b0);
    chk("rd count", 16'h0000, count_o);
    chk("rd writes", 16'h0003, 16'(wq.size()));
    for (int i = 0; i < 3; i++) chk("rd mem", {8'h04 + 8'(i), 8'hC0 + 8'(i)}, wq[i]);
    lag = 3'h3;
    ent(16'h0020, 16'h0004, 16'h0000);
    cmd(16'h0001, 8'h00, 4'd1, 1'b1);
    chk("wr early", {8'h03, 8'h0C}, {count_o[7:0], status_o});
    chk("wr dir", 16'h0000, 16'(wq.size()));
    lag = 3'h0;
    ent(16'h0030, 16'h0002, 16'h0000);
    cmd(16'h0004, 8'h02, 4'd0, 1'b0);
    chk("err stat", {8'h02, 8'h02}, {count_o[7:0], status_o});
    cmd(16'h0000, 8'h00, 4'd0, 1'b0);
    chk("test io", 16'h0002, count_o);
    cmd(16'h000C, 8'h00, 4'd2, 1'b0);
    for (int i = 0; i < 2; i++) chk("rdbk mem", {8'h0C - 8'(i), 8'hC0 + 8'(i)}, wq[i]);
    ent(16'h0000, 16'h0001, 16'h0000);
    cmd(16'h0003, 8'h00, 4'd1, 1'b0);
    chk("ctl count", 16'h0000, count_o);
    fn(4'h7, 16'h0000);
    ent(16'h0041, 16'h0001, 16'h0001);
    ent(16'h0012, 16'h0001, 16'h0001);
    cmd(16'h0002, 8'h00, 4'd2, 1'b0);
    chk("chain mem", {8'h04, 8'hC0, 8'h10, 8'hC1}, {wq[0], wq[1]});
    chk("chain count", 16'h0000, count_o);
    @(negedge core_clk_i);
    fn(4'h8, 16'h0000);
    @(negedge core_clk_i);
    chk("rd addr 0", 16'h0016, result_o);
    fn(4'h8, 16'h0001);
    @(negedge core_clk_i);
    chk("rd addr 1", 16'h0045, result_o);
    summarize();
  end
endmodule
